// [external_interrupt_detect.sv]
// External interrupt detector: eight active-low request pins and the NMI pin,
// request flags, enables, priority selection and an APB register slave.
// Assumes pins and control inputs are synchronous to ref_clk, except the
// request pins and NMI pin, which are resynchronised here.
// excAck is a one-cycle pulse with its vector.
// Flags are read over APB only; status vector, level, request and wakeup are also outputs.
//
// The register offsets and register access over APB were decided locally.
`default_nettype none

module external_interrupt_detect
    import ext_int_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic srst,

    // Power state.
    // hwStandby acts as a synchronous reset.
    input wire logic hwStandby,
    input wire logic swStandby,

    // External request pins.
    // Both resynchronised here.
    input wire logic [7:0] irqPin_n,
    input wire logic nmiPin,

    // CPU side.
    // excAckVector is valid with excAck.
    input wire logic [2:0] cpuMaskLevel,
    input wire logic excAck,
    input wire logic [7:0] excAckVector,

    // Transfer controller activation per pin.
    // Select bit zero: activation clears.
    input wire logic [7:0] transferActivate,
    input wire logic [7:0] transferIntSelect,

    // Internal peripheral sources.
    input wire logic [3:0] periphFlag,
    input wire logic [3:0] periphEnable,

    // APB slave.
    // pslverr marks an unmapped offset.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,

    // Interrupt outputs.
    // All registered levels.
    output logic intRequest,
    output logic [7:0] intVector,
    output logic [2:0] intLevel,
    output logic nmiRequest,
    output logic wakeup,
    output logic [3:0] periphRequest
);

    ////////////////////////////////////////////////////////////////////////////
    // Address decoder, shared by the read and write paths.
    // Unlisted offsets give SEL_NONE.
    function automatic logic [2:0] regSelect(input logic [11:0] addr);
        logic [2:0] sel;

        sel = SEL_NONE;
        if (addr == OFS_SENSE) begin
            sel = SEL_SENSE;
        end else if (addr == OFS_FLAGS) begin
            sel = SEL_FLAGS;
        end else if (addr == OFS_ENABLE) begin
            sel = SEL_ENABLE;
        end else if (addr == OFS_SYSCTL) begin
            sel = SEL_SYSCTL;
        end else if (addr == OFS_PRIORITY) begin
            sel = SEL_PRIORITY;
        end else if (addr == OFS_STATUS) begin
            sel = SEL_STATUS;
        end

        return sel;
    endfunction

    // Merges write data into an old word under the byte strobes.
    // Lanes with no strobe keep the old byte.
    function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                               input logic [31:0] wdata,
                                               input logic [3:0] strb);
        logic [31:0] res;

        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = wdata[8*b +: 8];
            end
        end

        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State record and its next value.
    // cur is the only register in the block.
    state_t cur;
    state_t next_state;

    // Bus decode and handshake.
    logic [2:0] sel;
    logic setupCycle;
    logic accessDone;
    logic [31:0] readWord;
    logic [31:0] merged;

    // Flag clear and gating.
    logic [7:0] swClear;
    logic [7:0] pendingGated;

    // Per-pin scratch.
    logic [1:0] mode;
    logic pinLow;
    logic pinFall;
    logic pinRise;
    logic setEvent;
    logic clrEvent;
    logic pinAck;

    // NMI and arbitration scratch.
    logic nmiEdge;
    logic bestValid;
    logic [2:0] bestLevel;
    logic [2:0] bestIndex;
    logic [2:0] lvl;

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic: bus slave, detection, flags and arbitration.
    // It reads only cur and the inputs.
    always_comb begin
        // Fields hold unless changed below.
        next_state = cur;
        sel = regSelect(paddr);
        setupCycle = psel & penable & ~cur.pready;
        accessDone = psel & penable & cur.pready;

        // Scratch starts at zero: no latches.
        readWord = 32'h0000_0000;
        merged = 32'h0000_0000;
        swClear = 8'h00;
        pendingGated = 8'h00;

        // Loop scratch.
        mode = SENSE_LOW;
        pinLow = 1'b0;
        pinFall = 1'b0;
        pinRise = 1'b0;
        setEvent = 1'b0;
        clrEvent = 1'b0;
        pinAck = 1'b0;

        nmiEdge = 1'b0;
        bestValid = 1'b0;
        bestLevel = 3'h0;
        bestIndex = 3'h0;
        lvl = 3'h0;

        // Two-stage synchronisers followed by a previous-sample stage.
        // Reset loads the idle level: no edge.
        // Only syncB and prevSample feed the detectors.
        next_state.syncA = irqPin_n;
        next_state.syncB = cur.syncA;
        next_state.prevSample = cur.syncB;
        next_state.nmiSyncA = nmiPin;
        next_state.nmiSyncB = cur.nmiSyncA;
        next_state.nmiPrev = cur.nmiSyncB;

        // Read data is prepared in the first access cycle, one wait state.
        // Unmapped offsets read zero.
        if (sel == SEL_SENSE) begin
            readWord[15:0] = cur.senseSelect;
        end else if (sel == SEL_FLAGS) begin
            readWord[7:0] = cur.requestFlags;
        end else if (sel == SEL_ENABLE) begin
            readWord[7:0] = cur.enableReg;
        end else if (sel == SEL_SYSCTL) begin
            readWord[NMI_EDGE_BIT] = cur.nmiEdgeSelect;
        end else if (sel == SEL_PRIORITY) begin
            readWord[23:0] = cur.priorityLevels;
        end else if (sel == SEL_STATUS) begin
            readWord[STAT_VEC_LSB +: 8] = cur.intVector;
            readWord[STAT_LEVEL_LSB +: 3] = cur.intLevel;
            readWord[STAT_REQ_BIT] = cur.intRequest;
            readWord[STAT_NMI_BIT] = cur.nmiPending;
            readWord[STAT_WAKE_BIT] = cur.wakeup;
        end

        // pready stands for one cycle.
        next_state.pready = setupCycle;
        if (setupCycle) begin
            next_state.prdata = readWord;
            next_state.pslverr = (sel == SEL_NONE);
        end

        // Register writes take effect at the completing edge only.
        // The status word ignores writes.
        merged = mergeBytes(readWord, pwdata, pstrb);
        if (accessDone && pwrite) begin
            if (sel == SEL_SENSE) begin
                next_state.senseSelect = merged[15:0];
            end else if (sel == SEL_ENABLE) begin
                next_state.enableReg = merged[7:0];
            end else if (sel == SEL_SYSCTL) begin
                next_state.nmiEdgeSelect = merged[NMI_EDGE_BIT];
            end else if (sel == SEL_PRIORITY) begin
                next_state.priorityLevels = merged[23:0];
            end else if (sel == SEL_FLAGS && pstrb[0]) begin
                // Only bits seen as one and now written zero clear.
                swClear = cur.readArmed & ~pwdata[7:0];
                next_state.readArmed = 8'h00;
            end
        end

        // A completed read of the flags arms the bits that read back as one.
        // A flag write with pstrb[0] set disarms all bits.
        if (accessDone && !pwrite && sel == SEL_FLAGS) begin
            next_state.readArmed = cur.readArmed | cur.prdata[7:0];
        end

        // Per-pin detection and flag update; a set wins over any clear.
        // Level mode re-sets while the pin is low.
        // A hardware clear also disarms the bit.
        for (int i = 0; i < NUM_PINS; i++) begin
            mode = cur.senseSelect[2*i +: 2];
            pinLow = ~cur.syncB[i];
            pinFall = cur.prevSample[i] & ~cur.syncB[i];
            pinRise = ~cur.prevSample[i] & cur.syncB[i];
            case (mode)
                SENSE_LOW: setEvent = pinLow;
                SENSE_FALL: setEvent = pinFall;
                SENSE_RISE: setEvent = pinRise;
                default: setEvent = pinFall | pinRise;
            endcase

            // Only this pin's vector clears it.
            pinAck = excAck && (excAckVector == VEC_PIN_BASE + 8'(i));
            clrEvent = swClear[i];
            if (pinAck && (mode != SENSE_LOW || cur.syncB[i])) begin
                clrEvent = 1'b1;
            end
            if (transferActivate[i] && !transferIntSelect[i]) begin
                clrEvent = 1'b1;
            end

            next_state.requestFlags[i] = setEvent | (cur.requestFlags[i] & ~clrEvent);
            if (clrEvent) begin
                next_state.readArmed[i] = 1'b0;
            end
        end

        // NMI edge detection on the selected edge.
        // A steady pin gives no edge on reselect.
        if (cur.nmiEdgeSelect) begin
            nmiEdge = ~cur.nmiPrev & cur.nmiSyncB;
        end else begin
            nmiEdge = cur.nmiPrev & ~cur.nmiSyncB;
        end
        // Vector 7 acknowledge clears; an edge wins.
        next_state.nmiPending = nmiEdge |
            (cur.nmiPending & ~(excAck && excAckVector == VEC_NMI));
        // The pin output trails by one cycle.
        next_state.nmiRequest = cur.nmiPending;

        // Highest level wins; on equal levels the lower pin number wins.
        // Scanning down with >= favours low pins.
        // Disabled pins drop out here.
        pendingGated = cur.requestFlags & cur.enableReg;

        for (int i = NUM_PINS - 1; i >= 0; i--) begin
            lvl = cur.priorityLevels[3*i +: 3];
            if (pendingGated[i] && (!bestValid || lvl >= bestLevel)) begin
                bestValid = 1'b1;
                bestLevel = lvl;
                bestIndex = 3'(i);
            end
        end

        // NMI bypasses the mask; pins must beat the CPU mask level.
        // A level equal to the mask waits.
        if (cur.nmiPending) begin
            next_state.intRequest = 1'b1;
            next_state.intVector = VEC_NMI;
            next_state.intLevel = 3'h7;
        end else if (bestValid && bestLevel > cpuMaskLevel) begin
            next_state.intRequest = 1'b1;
            next_state.intVector = VEC_PIN_BASE + {5'h00, bestIndex};
            next_state.intLevel = bestLevel;
        end else begin
            next_state.intRequest = 1'b0;
            next_state.intVector = VEC_NONE;
            next_state.intLevel = 3'h0;
        end

        // Only NMI and the low three pins can leave software standby.
        // A level; it drops with swStandby.
        next_state.wakeup = swStandby &
            (cur.nmiPending | (|(pendingGated & WAKE_PIN_MASK)));

        // Peripheral requests need flag and enable; no mask state is touched here.
        // The block keeps no peripheral mask or mode.
        next_state.periphRequest = periphFlag & periphEnable;

        // Hardware standby returns every register to its reset value.
        // Last, so it overrides all above.
        if (hwStandby) begin
            next_state = STATE_RESET;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register with synchronous reset.
    // No clock enable: it loads every edge.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cur <= STATE_RESET;
        end else begin
            cur <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs come straight from the state register.
    // No logic follows the register.
    // Bus side.
    assign pready = cur.pready;
    assign pslverr = cur.pslverr;
    assign prdata = cur.prdata;

    // Interrupt side.
    assign intRequest = cur.intRequest;
    assign intVector = cur.intVector;
    assign intLevel = cur.intLevel;
    assign nmiRequest = cur.nmiRequest;
    assign wakeup = cur.wakeup;
    assign periphRequest = cur.periphRequest;

endmodule

`default_nettype wire

// [ext_int_pkg.sv]
// Constants, register map and state record for the external interrupt detector.
// Assumes a 25 MHz system clock and an APB register bus with 12 address bits.
`default_nettype none

package ext_int_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Sizes.
    localparam int unsigned NUM_PINS = 8;
    localparam int unsigned NUM_PERIPH = 4;
    localparam int unsigned ADDR_W = 12;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets.
    localparam logic [11:0] OFS_SENSE = 12'h000;
    localparam logic [11:0] OFS_FLAGS = 12'h004;
    localparam logic [11:0] OFS_ENABLE = 12'h008;
    localparam logic [11:0] OFS_SYSCTL = 12'h00C;
    localparam logic [11:0] OFS_PRIORITY = 12'h010;
    localparam logic [11:0] OFS_STATUS = 12'h014;

    // Register selector codes returned by the address decoder.
    localparam logic [2:0] SEL_NONE = 3'h0;
    localparam logic [2:0] SEL_SENSE = 3'h1;
    localparam logic [2:0] SEL_FLAGS = 3'h2;
    localparam logic [2:0] SEL_ENABLE = 3'h3;
    localparam logic [2:0] SEL_SYSCTL = 3'h4;
    localparam logic [2:0] SEL_PRIORITY = 3'h5;
    localparam logic [2:0] SEL_STATUS = 3'h6;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values and field positions.
    localparam logic [15:0] SENSE_RESET = 16'h0000;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [23:0] PRIORITY_RESET = 24'hFF_FFFF;
    localparam int unsigned NMI_EDGE_BIT = 0;
    localparam int unsigned STAT_VEC_LSB = 0;
    localparam int unsigned STAT_LEVEL_LSB = 8;
    localparam int unsigned STAT_REQ_BIT = 11;
    localparam int unsigned STAT_NMI_BIT = 12;
    localparam int unsigned STAT_WAKE_BIT = 13;

    // Sense selection codes, bit B above bit A.
    localparam logic [1:0] SENSE_LOW = 2'h0;
    localparam logic [1:0] SENSE_FALL = 2'h1;
    localparam logic [1:0] SENSE_RISE = 2'h2;
    localparam logic [1:0] SENSE_BOTH = 2'h3;

    // Vector numbers and the pins able to leave software standby.
    localparam logic [7:0] VEC_NONE = 8'h00;
    localparam logic [7:0] VEC_NMI = 8'h07;
    localparam logic [7:0] VEC_PIN_BASE = 8'h10;
    localparam logic [7:0] WAKE_PIN_MASK = 8'h07;

    ////////////////////////////////////////////////////////////////////////////
    // Whole state of the detector.
    typedef struct packed {
        logic [7:0] syncA;
        logic [7:0] syncB;
        logic [7:0] prevSample;
        logic nmiSyncA;
        logic nmiSyncB;
        logic nmiPrev;
        logic [15:0] senseSelect;
        logic [7:0] requestFlags;
        logic [7:0] readArmed;
        logic [7:0] enableReg;
        logic nmiEdgeSelect;
        logic [23:0] priorityLevels;
        logic nmiPending;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic intRequest;
        logic [7:0] intVector;
        logic [2:0] intLevel;
        logic nmiRequest;
        logic wakeup;
        logic [3:0] periphRequest;
    } state_t;

    localparam state_t STATE_RESET = '{
        syncA: 8'hFF, syncB: 8'hFF, prevSample: 8'hFF,
        nmiSyncA: 1'b1, nmiSyncB: 1'b1, nmiPrev: 1'b1,
        senseSelect: SENSE_RESET, requestFlags: FLAGS_RESET, readArmed: 8'h00,
        enableReg: ENABLE_RESET, nmiEdgeSelect: 1'b0, priorityLevels: PRIORITY_RESET,
        nmiPending: 1'b0, pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000,
        intRequest: 1'b0, intVector: VEC_NONE, intLevel: 3'h0, nmiRequest: 1'b0,
        wakeup: 1'b0, periphRequest: 4'h0
    };

endpackage

`default_nettype wire

// [ext_pin_source.sv]
// Model of the external devices that drive the request pins and the NMI pin.
// Assumes the bench asks for pin levels just after a rising edge.
`default_nettype none

module ext_pin_source (
    // Clock and pacing.
    input wire logic ref_clk,
    input wire logic slow,
    // Requested levels.
    input wire logic [7:0] wantPin_n,
    input wire logic wantNmi,
    // Pins.
    output logic [7:0] irqPin_n = 8'hFF,
    output logic nmiPin = 1'b1
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [8:0] stage = 9'h1FF;

    // Pins stay pure request inputs; a slow device answers one edge later.
    always_ff @(posedge ref_clk) begin
        stage <= {wantNmi, wantPin_n};
        {nmiPin, irqPin_n} <= slow ? stage : {wantNmi, wantPin_n};
    end
endmodule

`default_nettype wire

// [ext_int_assertions.sv]
// Checker for the external interrupt detector, bound to its top module.
// Assumes one clock; srst and hwStandby both clear all state.
`default_nettype none

module ext_int_checker
    import ext_int_pkg::*;
(
    // Clock and resets.
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic hwStandby,
    // Watched inputs.
    input wire logic [2:0] cpuMaskLevel,
    input wire logic swStandby,
    input wire logic [3:0] periphFlag,
    input wire logic [3:0] periphEnable,
    input wire logic psel,
    input wire logic penable,
    // Watched outputs.
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    input wire logic intRequest,
    input wire logic [7:0] intVector,
    input wire logic [2:0] intLevel,
    input wire logic wakeup,
    input wire logic [3:0] periphRequest
);
    timeunit 1ns;
    timeprecision 1ns;

    default clocking dcb @(posedge ref_clk); endclocking
    default disable iff (srst || hwStandby);

    ////////////////////////////////////////
    // Relations between requests and answers.
    reset_clear_a: assert property ($fell(srst) |-> !intRequest && !pready && prdata == 0)
        else $error("outputs not clear after reset");
    nmi_top_a: assert property (intRequest && intVector == VEC_NMI |-> intLevel == 3'h7)
        else $error("nmi not at top level");
    vec_range_a: assert property (intRequest && intVector != VEC_NMI |->
        intVector >= VEC_PIN_BASE && intVector <= 8'h17)
        else $error("pin vector out of range");
    idle_vec_a: assert property (!intRequest |-> intVector == VEC_NONE)
        else $error("vector shown without request");
    mask_level_a: assert property (intRequest && intVector != VEC_NMI |->
        intLevel > $past(cpuMaskLevel))
        else $error("request not above mask");
    periph_gate_a: assert property (!$past(srst) && !$past(hwStandby) |->
        periphRequest == $past(periphFlag & periphEnable))
        else $error("peripheral request not gated");
    wake_gate_a: assert property (wakeup |-> $past(swStandby))
        else $error("wakeup outside standby");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    apb_answer_a: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("apb answer not in second access cycle");
    refused_zero_a: assert property (pready && pslverr |-> prdata == 0)
        else $error("refused read returned data");

    // Main scenarios.
    cover property (intRequest && intVector == VEC_NMI);
    cover property (pready && pslverr);
    cover property (wakeup);
endmodule

bind external_interrupt_detect ext_int_checker i_chk (
    .ref_clk(ref_clk), .srst(srst), .hwStandby(hwStandby), .cpuMaskLevel(cpuMaskLevel),
    .swStandby(swStandby), .periphFlag(periphFlag), .periphEnable(periphEnable),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .intRequest(intRequest), .intVector(intVector), .intLevel(intLevel),
    .wakeup(wakeup), .periphRequest(periphRequest));

`default_nettype wire

// [tb_top.sv]
// Bench for the external interrupt detector, driven over APB and the pins.
// Assumes the pin source model and the bound checker are compiled with it.
`default_nettype none

module tb_top
    import ext_int_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic ref_clk = 1'b0;
    logic srst = 1'b1, hwStandby = 1'b0, swStandby = 1'b0, slow = 1'b0, wantNmi = 1'b1;
    logic [7:0] wantPin_n = 8'hFF, irqPin_n, excAckVector = 8'h00, transferActivate = 8'h00;
    logic [7:0] transferIntSelect = 8'hFF, intVector;
    logic [2:0] cpuMaskLevel = 3'h0, intLevel;
    logic [3:0] periphFlag = 4'h0, periphEnable = 4'h0, pstrb = 4'hF, periphRequest;
    logic nmiPin, excAck = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic pready, pslverr, intRequest, nmiRequest, wakeup;
    int mismatches = 0, samplesChecked = 0;

    ////////////////////////////////////////
    // Clock, far side and design.
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end

    ext_pin_source i_src (.ref_clk(ref_clk), .slow(slow), .wantPin_n(wantPin_n),
        .wantNmi(wantNmi), .irqPin_n(irqPin_n), .nmiPin(nmiPin));

    external_interrupt_detect i_dut (.ref_clk(ref_clk), .srst(srst), .hwStandby(hwStandby),
        .swStandby(swStandby), .irqPin_n(irqPin_n), .nmiPin(nmiPin),
        .cpuMaskLevel(cpuMaskLevel), .excAck(excAck), .excAckVector(excAckVector),
        .transferActivate(transferActivate), .transferIntSelect(transferIntSelect),
        .periphFlag(periphFlag), .periphEnable(periphEnable), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .pslverr(pslverr), .prdata(prdata), .intRequest(intRequest),
        .intVector(intVector), .intLevel(intLevel), .nmiRequest(nmiRequest),
        .wakeup(wakeup), .periphRequest(periphRequest));

    ////////////////////////////////////////
    // Verdict, comparison and bus tasks.
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", samplesChecked, mismatches);
        if (mismatches == 0 && samplesChecked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] got);
        samplesChecked++;
        if (got !== x) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, x, got);
        end
    endtask

    // One APB transfer; the request stands until pready is sampled high.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 16) begin
                mismatches++;
                report_and_stop();
            end
            @(posedge ref_clk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] x);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0000_0000, q, e);
        chk(nm, x, q);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic ack(input logic [7:0] v);
        excAckVector <= v;
        excAck <= 1'b1;
        @(posedge ref_clk);
        excAck <= 1'b0;
        @(posedge ref_clk);
    endtask

    ////////////////////////////////////////
    // Scenarios in order; a watchdog cuts a hang short.
    initial begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        report_and_stop();
    end

    initial begin
        logic [31:0] q;
        logic e;
        cyc(2);
        srst <= 1'b0;
        cyc(1);
        rd("sense", OFS_SENSE, 32'h0000_0000);
        rd("flags", OFS_FLAGS, 32'h0000_0000);
        rd("enable", OFS_ENABLE, 32'h0000_0000);
        rd("priority", OFS_PRIORITY, 32'h00FF_FFFF);
        // Pin 0 low level, pin 1 falling, pin 2 rising, pin 3 both edges.
        wr(OFS_SENSE, 32'h0000_00E4);
        wantPin_n <= 8'hF1;
        cyc(8);
        rd("fall flags", OFS_FLAGS, 32'h0000_000A);
        wr(OFS_FLAGS, 32'h0000_00FF);
        rd("write one", OFS_FLAGS, 32'h0000_000A);
        wr(OFS_FLAGS, 32'h0000_0000);
        rd("two step", OFS_FLAGS, 32'h0000_0000);
        wantPin_n <= 8'hFF;
        cyc(8);
        rd("rise flags", OFS_FLAGS, 32'h0000_000C);
        ack(VEC_PIN_BASE + 8'h03);
        rd("edge ack", OFS_FLAGS, 32'h0000_0004);
        wantPin_n <= 8'hFE;
        cyc(8);
        rd("level flag", OFS_FLAGS, 32'h0000_0005);
        chk("disabled", 32'h0, {31'h0, intRequest});
        wr(OFS_ENABLE, 32'h0000_0001);
        cyc(3);
        chk("pin0 vector", {24'h0, VEC_PIN_BASE}, {24'h0, intVector});
        chk("pin0 level", {29'h0, PRIORITY_RESET[2:0]}, {29'h0, intLevel});
        wantPin_n <= 8'hFF;
        cyc(6);
        ack(VEC_PIN_BASE);
        rd("level ack", OFS_FLAGS, 32'h0000_0004);
        transferIntSelect <= 8'hFB;
        transferActivate <= 8'h04;
        cyc(1);
        transferActivate <= 8'h00;
        cyc(2);
        rd("transfer", OFS_FLAGS, 32'h0000_0000);
        // NMI above a full mask, falling then rising edge, slow source.
        cpuMaskLevel <= 3'h7;
        slow <= 1'b1;
        wantNmi <= 1'b0;
        cyc(8);
        chk("nmi vector", {24'h0, VEC_NMI}, {24'h0, intVector});
        chk("nmi fall", 32'h1, {31'h0, nmiRequest});
        ack(VEC_NMI);
        wr(OFS_SYSCTL, 32'h0000_0001);
        cyc(3);
        chk("nmi acked", 32'h0, {31'h0, nmiRequest});
        wantNmi <= 1'b1;
        cyc(8);
        chk("nmi rise", 32'h1, {31'h0, nmiRequest});
        ack(VEC_NMI);
        slow <= 1'b0;
        cpuMaskLevel <= 3'h0;
        // Pin 5 may not wake from standby, pin 1 may.
        wr(OFS_ENABLE, 32'h0000_0020);
        swStandby <= 1'b1;
        wantPin_n <= 8'hDF;
        cyc(8);
        chk("pin5 vector", {24'h0, VEC_PIN_BASE + 8'h05}, {24'h0, intVector});
        rd("status", OFS_STATUS, 32'h0000_0F15);
        chk("no wake", 32'h0, {31'h0, wakeup});
        cpuMaskLevel <= 3'h7;
        cyc(3);
        chk("masked", 32'h0, {31'h0, intRequest});
        wr(OFS_ENABLE, 32'h0000_0022);
        wantPin_n <= 8'hDD;
        cyc(8);
        chk("wake", 32'h1, {31'h0, wakeup});
        // Pin 1 at level 6 beats pin 5 at level 4 above mask 5.
        wr(OFS_PRIORITY, 32'h00FE_7FF7);
        cpuMaskLevel <= 3'h5;
        cyc(3);
        chk("prio level", 32'h6, {29'h0, intLevel});
        chk("pin1 vector", {24'h0, VEC_PIN_BASE + 8'h01}, {24'h0, intVector});
        apb(1'b0, 12'h020, 32'h0000_0000, q, e);
        chk("unmapped err", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, q);
        periphFlag <= 4'hF;
        periphEnable <= 4'h5;
        cyc(3);
        chk("periph", 32'h5, {28'h0, periphRequest});
        periphFlag <= 4'h0;
        swStandby <= 1'b0;
        wantPin_n <= 8'hFF;
        cyc(6);
        hwStandby <= 1'b1;
        cyc(2);
        hwStandby <= 1'b0;
        cyc(1);
        rd("sense standby", OFS_SENSE, 32'h0000_0000);
        rd("flags standby", OFS_FLAGS, 32'h0000_0000);
        rd("enable standby", OFS_ENABLE, 32'h0000_0000);
        rd("prio standby", OFS_PRIORITY, 32'h00FF_FFFF);
        report_and_stop();
    end
endmodule

`default_nettype wire
